/* File: hdl/phy_sideband_pkg.sv */
// Shared constants for the PHY side-band control block.
// Assumes a 125 MHz system clock and word-aligned AHB-Lite access.
package phy_sideband_pkg;
	localparam int unsigned CLOCK_MHZ = 125;
	localparam int unsigned REF_MHZ = 50;
	// Reference tick accumulator: REF_MHZ per CLOCK_MHZ
	localparam logic [7:0] REF_ACC_STEP = 8'h32;
	localparam logic [7:0] REF_ACC_WRAP = 8'h7D;
	// Deep power-down idle time
	localparam longint unsigned DPD_IDLE_S = 32;
	localparam longint unsigned DPD_IDLE_CYC = DPD_IDLE_S * CLOCK_MHZ * 64'd1000000;
	// Dwell on one pairing while hunting for link
	localparam int unsigned MDIX_DWELL_US = 1000;
	localparam int unsigned MDIX_DWELL_CYC = MDIX_DWELL_US * CLOCK_MHZ;
	// Register byte offsets
	localparam logic [7:0] OFS_MDIX = 8'h00;
	localparam logic [7:0] OFS_POWER = 8'h04;
	localparam logic [7:0] OFS_LED = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	// Field positions
	localparam int unsigned MDIX_AUTO_BIT = 9;
	localparam int unsigned MDIX_PAIR_BIT = 8;
	localparam int unsigned SOFT_RESET_BIT = 0;
	localparam int unsigned POWER_LSB = 4;
	localparam int unsigned SEL_W = 3;
	// Reset values
	localparam logic MDIX_AUTO_RST = 1'b1;
	localparam logic MDIX_PAIR_RST = 1'b0;
	localparam logic [4:0] POWER_RST = 5'h1F;
	localparam logic [14:0] LED_RST = 15'h3110;
	// Indicator functions
	localparam logic [2:0] IND_LINK = 3'h0;
	localparam logic [2:0] IND_ACT = 3'h1;
	localparam logic [2:0] IND_TX = 3'h2;
	localparam logic [2:0] IND_RX = 3'h3;
	localparam logic [2:0] IND_COL = 3'h4;
	localparam logic [2:0] IND_SPEED = 3'h5;
	localparam logic [2:0] IND_DUPLEX = 3'h6;
	typedef enum logic [2:0] {
		MDIX_STRAIGHT = 3'b001,
		MDIX_CROSSED = 3'b010,
		MDIX_HUNT = 3'b100
	} mdix_mode_e;
endpackage : phy_sideband_pkg

/* File: hdl/indicator_pin.sv */
// One multi-function pin: strap input during reset, indicator output after.
// Assumes the pin input level is synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module indicator_pin
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Selection and status
	input wire logic [2:0] funcSel,
	input wire logic [6:0] statusVec,
	// Pin
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOeN,
	output logic strapLevel
);
	logic captured_ff;
	logic strap_ff;
	logic drive_ff;
	logic level_ff;
	logic active;

	assign active = (funcSel < 3'h7) ? statusVec[funcSel] : 1'b0;
	assign pinOut = level_ff;
	assign pinOeN = ~drive_ff;
	assign strapLevel = strap_ff;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			captured_ff <= 1'b0;
			strap_ff <= 1'b0;
		end
		else if (!captured_ff)
		begin
			captured_ff <= 1'b1;
			strap_ff <= pinIn;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			drive_ff <= 1'b0;
		else
			drive_ff <= captured_ff;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			level_ff <= 1'b0;
		else if (!captured_ff)
			level_ff <= pinIn;
		else
			level_ff <= active ? ~strap_ff : strap_ff;
	end
endmodule : indicator_pin
`default_nettype wire

/* File: hdl/pair_select.sv */
// Straight or crossed pair choice from pin, register bits and link state.
// Assumes linkUp and signalDetect are synchronous levels.
`timescale 1ns/10ps
`default_nettype none
module pair_select
#(
	parameter int unsigned DWELL_CYC = phy_sideband_pkg::MDIX_DWELL_CYC
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic softRst,
	// Controls
	input wire logic autoPin,
	input wire logic autoReg,
	input wire logic pairReg,
	input wire logic linkUp,
	input wire logic signalDetect,
	// Results
	output logic crossed,
	output logic settled
);
	phy_sideband_pkg::mdix_mode_e mode;
	logic [31:0] dwell_ff;
	logic crossed_ff;
	logic settled_ff;

	assign crossed = crossed_ff;
	assign settled = settled_ff;

	always_comb
	begin
		if (!autoReg)
			mode = pairReg ? phy_sideband_pkg::MDIX_CROSSED : phy_sideband_pkg::MDIX_STRAIGHT;
		else if (!autoPin)
			mode = phy_sideband_pkg::MDIX_STRAIGHT;
		else
			mode = phy_sideband_pkg::MDIX_HUNT;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			crossed_ff <= 1'b0;
			dwell_ff <= 32'h0;
		end
		else if (softRst)
		begin
			crossed_ff <= 1'b0;
			dwell_ff <= 32'h0;
		end
		else
		begin
			case (mode)
				phy_sideband_pkg::MDIX_STRAIGHT:
				begin
					crossed_ff <= 1'b0;
					dwell_ff <= 32'h0;
				end
				phy_sideband_pkg::MDIX_CROSSED:
				begin
					crossed_ff <= 1'b1;
					dwell_ff <= 32'h0;
				end
				default:
				begin
					if (linkUp || signalDetect)
						dwell_ff <= 32'h0;
					else if (dwell_ff >= DWELL_CYC - 1)
					begin
						dwell_ff <= 32'h0;
						crossed_ff <= ~crossed_ff;
					end
					else
						dwell_ff <= dwell_ff + 32'h1;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			settled_ff <= 1'b0;
		else
			settled_ff <= !softRst && (mode != phy_sideband_pkg::MDIX_HUNT || linkUp || signalDetect);
	end
endmodule : pair_select
`default_nettype wire

/* File: hdl/phy_sideband_ctrl.sv */
// PHY side-band control: RMII receive outputs, pair crossover,
// deep power-down, strap/indicator pins, AHB-Lite registers.
// Assumes all inputs are synchronous to clock; the receive stream
// offers one di-bit per reference tick.
`timescale 1ns/10ps
`default_nettype none
module phy_sideband_ctrl
#(
	parameter longint unsigned DPD_CYC = phy_sideband_pkg::DPD_IDLE_CYC,
	parameter int unsigned DWELL_CYC = phy_sideband_pkg::MDIX_DWELL_CYC
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Recovered receive stream
	input wire logic carrier,
	input wire logic rxValid,
	input wire logic [1:0] rxBits,
	input wire logic codeError,
	// Line and MAC status
	input wire logic linkUp,
	input wire logic signalDetect,
	input wire logic txEnable,
	input wire logic txActive,
	input wire logic rxActive,
	input wire logic collision,
	input wire logic speed100,
	input wire logic fullDuplex,
	input wire logic autoCrossoverEnable,
	// RMII receive toward MAC
	output logic [1:0] rxd,
	output logic crsDv,
	output logic rxEr,
	// Pair routing
	output logic pairACarriesTx,
	output logic pairBCarriesTx,
	output logic negotiationAllowed,
	// Power
	output logic deepPowerDown,
	output logic [4:0] sectionOff,
	// Multi-function pins
	input wire logic [4:0] indicatorIn,
	output logic [4:0] indicatorOut,
	output logic [4:0] indicatorOeN,
	output logic [4:0] mgmtAddrStrap
);
	logic [7:0] refAcc_ff;
	logic refTick_ff;
	logic [7:0] nxt_refAcc;
	logic autoReg_ff;
	logic pairReg_ff;
	logic softRst_ff;
	logic [4:0] power_ff;
	logic [14:0] led_ff;
	logic wrPend_ff;
	logic [7:0] wrAddr_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rxd_ff;
	logic crsDv_ff;
	logic rxEr_ff;
	logic phase_ff;
	logic tail_ff;
	logic [63:0] idle_ff;
	logic dpd_ff;
	logic [4:0] off_ff;
	logic pairA_ff;
	logic pairB_ff;
	logic crossed;
	logic settled;
	logic [6:0] statusVec;
	logic [4:0] straps;
	logic [31:0] rdValue;
	logic [7:0] addrLo;
	logic takeReq;

	assign hrdata = rdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rxd = rxd_ff;
	assign crsDv = crsDv_ff;
	assign rxEr = rxEr_ff;
	assign pairACarriesTx = pairA_ff;
	assign pairBCarriesTx = pairB_ff;
	assign deepPowerDown = dpd_ff;
	assign sectionOff = off_ff;
	assign statusVec = {fullDuplex, speed100, collision, rxActive, txActive, txActive | rxActive, linkUp};
	assign addrLo = haddr[7:0];
	assign takeReq = hsel && htrans[1] && hready;
	assign nxt_refAcc = refAcc_ff + phy_sideband_pkg::REF_ACC_STEP;

	// 50 MHz tick from 125 MHz, two in five
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			refAcc_ff <= 8'h00;
			refTick_ff <= 1'b0;
		end
		else if (nxt_refAcc >= phy_sideband_pkg::REF_ACC_WRAP)
		begin
			refAcc_ff <= nxt_refAcc - phy_sideband_pkg::REF_ACC_WRAP;
			refTick_ff <= 1'b1;
		end
		else
		begin
			refAcc_ff <= nxt_refAcc;
			refTick_ff <= 1'b0;
		end
	end

	// Read mux, evaluated in the address phase
	always_comb
	begin
		rdValue = 32'h0;
		if (addrLo == phy_sideband_pkg::OFS_MDIX)
		begin
			rdValue[phy_sideband_pkg::MDIX_AUTO_BIT] = autoReg_ff;
			rdValue[phy_sideband_pkg::MDIX_PAIR_BIT] = pairReg_ff;
		end
		else if (addrLo == phy_sideband_pkg::OFS_POWER)
			rdValue[8:4] = power_ff;
		else if (addrLo == phy_sideband_pkg::OFS_LED)
			rdValue[14:0] = led_ff;
		else if (addrLo == phy_sideband_pkg::OFS_STATUS)
			rdValue = {22'h0, crossed, settled, dpd_ff, linkUp, straps, 1'b0};
	end

	// Address phase capture and read data
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 8'h00;
			rdata_ff <= 32'h0;
		end
		else
		begin
			wrPend_ff <= takeReq && hwrite && (haddr[31:8] == 24'h0);
			wrAddr_ff <= addrLo;
			if (takeReq && !hwrite && haddr[31:8] == 24'h0)
				rdata_ff <= rdValue;
			else if (takeReq)
				rdata_ff <= 32'h0;
		end
	end

	// Register writes in the data phase
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			autoReg_ff <= phy_sideband_pkg::MDIX_AUTO_RST;
			pairReg_ff <= phy_sideband_pkg::MDIX_PAIR_RST;
			softRst_ff <= 1'b0;
			power_ff <= phy_sideband_pkg::POWER_RST;
			led_ff <= phy_sideband_pkg::LED_RST;
		end
		else
		begin
			softRst_ff <= 1'b0;
			if (wrPend_ff && wrAddr_ff == phy_sideband_pkg::OFS_MDIX)
			begin
				autoReg_ff <= hwdata[phy_sideband_pkg::MDIX_AUTO_BIT];
				pairReg_ff <= hwdata[phy_sideband_pkg::MDIX_PAIR_BIT];
				softRst_ff <= hwdata[phy_sideband_pkg::SOFT_RESET_BIT];
			end
			else if (wrPend_ff && wrAddr_ff == phy_sideband_pkg::OFS_POWER)
				power_ff <= hwdata[8:4];
			else if (wrPend_ff && wrAddr_ff == phy_sideband_pkg::OFS_LED)
				led_ff <= hwdata[14:0];
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			crsDv_ff <= 1'b0;
			phase_ff <= 1'b0;
			tail_ff <= 1'b0;
		end
		else if (softRst_ff || dpd_ff)
		begin
			crsDv_ff <= 1'b0;
			phase_ff <= 1'b0;
			tail_ff <= 1'b0;
		end
		else if (refTick_ff)
		begin
			phase_ff <= rxValid ? ~phase_ff : 1'b0;
			if (carrier && !tail_ff)
				crsDv_ff <= 1'b1;
			else if (rxValid && (tail_ff || !phase_ff))
			begin
				tail_ff <= 1'b1;
				crsDv_ff <= phase_ff;
			end
			else if (!rxValid)
			begin
				tail_ff <= 1'b0;
				crsDv_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			rxd_ff <= 2'b00;
		else if (softRst_ff || dpd_ff)
			rxd_ff <= 2'b00;
		else if (refTick_ff)
			rxd_ff <= rxValid ? rxBits : 2'b00;
	end

	// error held until the next reference tick
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			rxEr_ff <= 1'b0;
		else if (softRst_ff)
			rxEr_ff <= 1'b0;
		else if (refTick_ff)
			rxEr_ff <= rxValid && codeError;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			idle_ff <= 64'h0;
			dpd_ff <= 1'b0;
		end
		else if (softRst_ff || linkUp || txEnable || signalDetect)
		begin
			idle_ff <= 64'h0;
			dpd_ff <= 1'b0;
		end
		else if (idle_ff >= DPD_CYC - 64'd1)
			dpd_ff <= 1'b1;
		else
			idle_ff <= idle_ff + 64'h1;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			off_ff <= 5'h00;
		else
			off_ff <= dpd_ff ? power_ff : 5'h00;
	end

	pair_select #(
		.DWELL_CYC(DWELL_CYC)
	) u_pair (
		.clock(clock),
		.rst(rst),
		.softRst(softRst_ff),
		.autoPin(autoCrossoverEnable),
		.autoReg(autoReg_ff),
		.pairReg(pairReg_ff),
		.linkUp(linkUp),
		.signalDetect(signalDetect),
		.crossed(crossed),
		.settled(settled)
	);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pairA_ff <= 1'b1;
			pairB_ff <= 1'b0;
			negotiationAllowed <= 1'b0;
		end
		else
		begin
			pairA_ff <= ~crossed;
			pairB_ff <= crossed;
			negotiationAllowed <= settled;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_pin
			indicator_pin u_pin (
				.clock(clock),
				.rst(rst),
				.funcSel(led_ff[gi * 3 +: 3]),
				.statusVec(statusVec),
				.pinIn(indicatorIn[gi]),
				.pinOut(indicatorOut[gi]),
				.pinOeN(indicatorOeN[gi]),
				.strapLevel(straps[gi])
			);
		end
	endgenerate

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			mgmtAddrStrap <= 5'h00;
		else
			mgmtAddrStrap <= {3'b000, straps[1:0]};
	end
endmodule : phy_sideband_ctrl
`default_nettype wire

/* File: verification/phy_sideband_ctrl_props.sv */
// Concurrent checks on the PHY side-band block ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module phy_sideband_ctrl_props
#(
	parameter longint unsigned DPD_CYC = 200
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Receive side
	input wire logic carrier,
	input wire logic rxValid,
	input wire logic [1:0] rxBits,
	input wire logic codeError,
	input wire logic [1:0] rxd,
	input wire logic crsDv,
	input wire logic rxEr,
	// Status, pairs and power
	input wire logic linkUp,
	input wire logic signalDetect,
	input wire logic txEnable,
	input wire logic pairACarriesTx,
	input wire logic pairBCarriesTx,
	input wire logic deepPowerDown,
	// Pins
	input wire logic [4:0] indicatorIn,
	input wire logic [4:0] indicatorOut,
	input wire logic [4:0] indicatorOeN,
	input wire logic [4:0] mgmtAddrStrap
);
	logic [63:0] idleCnt;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Consecutive cycles with link, signal and transmit all low
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			idleCnt <= '0;
		else if (linkUp || txEnable || signalDetect)
			idleCnt <= '0;
		else
			idleCnt <= idleCnt + 64'h1;
	end
	sequence s_frame;
		(carrier && rxValid && $stable(rxBits))[*5];
	endsequence
	sequence s_quiet;
		(!carrier && !rxValid)[*5];
	endsequence
	a_rx_data: assert property (s_frame |-> crsDv && rxd == rxBits)
		else $error("rxd does not carry the received di-bit");
	a_rx_idle: assert property (s_quiet |-> rxd == 2'b00 && !crsDv)
		else $error("receive outputs not idle");
	a_rx_error: assert property ((carrier && rxValid && codeError)[*5] |-> rxEr)
		else $error("rxEr missing on code error");
	a_strap_take: assert property ($past(rst) |-> ##2 mgmtAddrStrap == {3'b000, $past(indicatorIn[1:0], 2)})
		else $error("address straps not captured at reset exit");
	a_pins_out: assert property (!$past(rst) && !$past(rst, 2) |-> indicatorOeN == 5'h00)
		else $error("indicator pins not driving");
	a_pins_in: assert property (@(posedge clock) disable iff (1'b0) rst |-> indicatorOeN == 5'h1F)
		else $error("indicator pins driving in reset");
	a_pair_one: assert property (pairACarriesTx != pairBCarriesTx)
		else $error("pair routing not exclusive");
	a_led_invert: assert property (linkUp[*4] |-> indicatorOut[0] != mgmtAddrStrap[0])
		else $error("asserted pin level not inverse of strap");
	a_wake_fast: assert property (deepPowerDown && (linkUp || txEnable || signalDetect) |=> !deepPowerDown)
		else $error("late wake from power-down");
	a_idle_time: assert property ($rose(deepPowerDown) |-> idleCnt + 64'd2 >= DPD_CYC && idleCnt <= DPD_CYC + 64'd2)
		else $error("power-down entry at wrong idle time");
endmodule : phy_sideband_ctrl_props
bind phy_sideband_ctrl phy_sideband_ctrl_props #(.DPD_CYC(DPD_CYC)) phy_sideband_ctrl_props_inst
(
	.clock, .rst, .carrier, .rxValid, .rxBits, .codeError, .rxd, .crsDv, .rxEr,
	.linkUp, .signalDetect, .txEnable, .pairACarriesTx, .pairBCarriesTx, .deepPowerDown,
	.indicatorIn, .indicatorOut, .indicatorOeN, .mgmtAddrStrap
);
`default_nettype wire

/* File: verification/rmii_mac_model.sv */
// MAC-side receive model for the reduced media independent interface.
// Assumes the block's clock; bench requests transmit through txReq.
`timescale 1ns/10ps
`default_nettype none
module rmii_mac_model
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Receive from the PHY
	input wire logic [1:0] rxd,
	input wire logic crsDv,
	input wire logic rxEr,
	// Transmit request
	input wire logic txReq,
	output logic txEnable,
	// Observations
	output logic [1:0] lastBits,
	output logic errSeen
);
	assign txEnable = txReq;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			lastBits <= 2'b00;
			errSeen <= 1'b0;
		end
		else if (crsDv)
		begin
			lastBits <= rxd;
			errSeen <= errSeen | rxEr;
		end
	end
endmodule : rmii_mac_model
`default_nettype wire

/* File: verification/test_phy_sideband_ctrl.sv */
// Self-checking bench for the PHY side-band block.
// Assumes shortened power-down and dwell counts at the instance.
`timescale 1ns/10ps
`default_nettype none
module test_phy_sideband_ctrl;
	localparam longint unsigned DEEP_POWER_DOWN = 200;
	localparam logic [4:0] STRAP = 5'b10110;
	logic clock = 1'b0, rst = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = 2'b00, rxBits = 2'b00, rxd, lastBits;
	logic [2:0] hsize = 3'b010;
	logic carrier = 1'b0, rxValid = 1'b0, codeError = 1'b0, linkUp = 1'b1, signalDetect = 1'b0;
	logic txReq = 1'b1, txActive = 1'b0, rxActive = 1'b0, collision = 1'b0, speed100 = 1'b0;
	logic fullDuplex = 1'b0, autoCrossoverEnable = 1'b1, txEnable, crsDv, rxEr, errSeen;
	logic pairACarriesTx, pairBCarriesTx, negotiationAllowed, deepPowerDown;
	logic [4:0] sectionOff, indicatorIn, indicatorOut, indicatorOeN, mgmtAddrStrap;
	int n_mismatch = 0, num_checks = 0;
	assign hready = hreadyout;
	assign indicatorIn = (indicatorOeN & STRAP) | (~indicatorOeN & indicatorOut);
	always #4 clock = ~clock;
	phy_sideband_ctrl #(.DPD_CYC(DEEP_POWER_DOWN), .DWELL_CYC(50)) phy_sideband_ctrl_inst
	(
		.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
		.hresp, .carrier, .rxValid, .rxBits, .codeError, .linkUp, .signalDetect, .txEnable, .txActive,
		.rxActive, .collision, .speed100, .fullDuplex, .autoCrossoverEnable, .rxd, .crsDv, .rxEr,
		.pairACarriesTx, .pairBCarriesTx, .negotiationAllowed, .deepPowerDown, .sectionOff,
		.indicatorIn, .indicatorOut, .indicatorOeN, .mgmtAddrStrap
	);
	rmii_mac_model rmii_mac_model_inst
	(
		.clock, .rst, .rxd, .crsDv, .rxEr, .txReq, .txEnable, .lastBits, .errSeen
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		@(posedge clock);
		while (hreadyout !== 1'b1)
			@(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge clock);
		while (hreadyout !== 1'b1)
			@(posedge clock);
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, {24'h0, a}, d, x);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, {24'h0, a}, 32'h0, x);
		check(x, e);
	endtask : rd
	task automatic t_reset;
		logic [31:0] v;
		rd(phy_sideband_pkg::OFS_MDIX, 32'h0000_0200);
		rd(phy_sideband_pkg::OFS_POWER, 32'h0000_01F0);
		rd(phy_sideband_pkg::OFS_LED, 32'h0000_3110);
		bus(1'b0, 32'h0000_0100, 32'h0, v);
		check(v, 32'h0);
		bus(1'b0, 32'h0000_000C, 32'h0, v);
		check(v & 32'h3E, 32'h2C);
		check(32'(mgmtAddrStrap), 32'h2);
		check(32'(indicatorOeN), 32'h0);
		check({31'h0, hresp}, 32'h0);
	endtask : t_reset
	task automatic t_rx;
		logic [1:0] seen;
		seen = 2'b00;
		carrier <= 1'b1;
		rxValid <= 1'b1;
		rxBits <= 2'b10;
		repeat (8) @(posedge clock);
		check(32'(rxd), 32'h2);
		check(32'(crsDv), 32'h1);
		check(32'(lastBits), 32'h2);
		check(32'(errSeen), 32'h0);
		codeError <= 1'b1;
		repeat (8) @(posedge clock);
		check(32'(rxEr), 32'h1);
		codeError <= 1'b0;
		carrier <= 1'b0;
		repeat (14)
		begin
			@(posedge clock);
			seen = seen | (crsDv ? 2'b10 : 2'b01);
		end
		check(32'(seen), 32'h3);
		check(32'(errSeen), 32'h1);
		rxValid <= 1'b0;
		repeat (8) @(posedge clock);
		check({29'h0, crsDv, rxd}, 32'h0);
	endtask : t_rx
	task automatic t_mdix;
		logic [1:0] seen;
		seen = 2'b00;
		wr(phy_sideband_pkg::OFS_MDIX, 32'h0000_0100);
		repeat (3) @(posedge clock);
		check(32'(pairBCarriesTx), 32'h1);
		wr(phy_sideband_pkg::OFS_MDIX, 32'h0000_0000);
		repeat (3) @(posedge clock);
		check(32'(pairACarriesTx), 32'h1);
		autoCrossoverEnable <= 1'b0;
		linkUp <= 1'b0;
		wr(phy_sideband_pkg::OFS_MDIX, 32'h0000_0200);
		repeat (120) @(posedge clock);
		check(32'(pairACarriesTx), 32'h1);
		autoCrossoverEnable <= 1'b1;
		repeat (120)
		begin
			@(posedge clock);
			seen = seen | {pairBCarriesTx, pairACarriesTx};
		end
		check(32'(seen), 32'h3);
		check(32'(negotiationAllowed), 32'h0);
		linkUp <= 1'b1;
		repeat (5) @(posedge clock);
		check(32'(negotiationAllowed), 32'h1);
	endtask : t_mdix
	task automatic t_power;
		wr(phy_sideband_pkg::OFS_POWER, 32'h0000_00A0);
		linkUp <= 1'b0;
		txReq <= 1'b0;
		repeat (DEEP_POWER_DOWN - 10) @(posedge clock);
		check(32'(deepPowerDown), 32'h0);
		repeat (20) @(posedge clock);
		check(32'(deepPowerDown), 32'h1);
		check(32'(sectionOff), 32'h0A);
		txReq <= 1'b1;
		repeat (3) @(posedge clock);
		check({27'h0, sectionOff}, 32'h0);
		check(32'(deepPowerDown), 32'h0);
		linkUp <= 1'b1;
	endtask : t_power
	task automatic t_soft;
		wr(phy_sideband_pkg::OFS_MDIX, 32'h0000_0201);
		repeat (3) @(posedge clock);
		check({22'h0, indicatorOeN, mgmtAddrStrap}, 32'h2);
		rd(phy_sideband_pkg::OFS_MDIX, 32'h0000_0200);
	endtask : t_soft
	task automatic t_led;
		for (int c = 0; c < 8; c++)
		begin
			{txActive, rxActive, collision, speed100, fullDuplex} <= (c % 2 == 0) ? 5'h1F : 5'h00;
			wr(phy_sideband_pkg::OFS_LED, {17'h0, 3'b011, 3'(c), 9'h110});
			repeat (4) @(posedge clock);
			check(32'(indicatorOut[3]), (c % 2 == 0) ? 32'h1 : 32'h0);
		end
	endtask : t_led
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	initial
	begin
		rst <= 1'b1;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		t_reset();
		t_rx();
		t_mdix();
		t_power();
		t_soft();
		t_led();
		stop_test();
	end
	initial
	begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		stop_test();
	end
endmodule : test_phy_sideband_ctrl
`default_nettype wire
